//--- mhs_checker.sv
// port assertions for the meter host pin block
`timescale 1ns/1ns
module mhs_checker (
	input wire        i_mclk,
	input wire        i_resetn,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [31:0] o_prdata,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        i_cs_n,
	input wire        o_dout,
	input wire        o_dout_oe_n,
	input wire        i_sclk,
	input wire        o_irq_out,
	input wire        o_irq_oe_n,
	input wire        o_reactive_pulse_out
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	// mask write that clears enable bits 2:0 (bits 7:3 are not checked)
	wire mask_off = i_psel && i_penable && i_pwrite && i_paddr == 12'h010 && i_pwdata[2:0] == 3'h0;
	irq_od_a: assert property (!o_irq_out) else $error("irq data high");
	apb_ans_a: assert property (i_psel && !i_penable |=> o_pready) else $error("late pready");
	apb_one_a: assert property (o_pready |=> !o_pready) else $error("pready held");
	err_rdy_a: assert property (o_pslverr |-> o_pready && o_prdata == 0) else $error("bad error");
	cs_off_a: assert property (i_cs_n [*3] |-> o_dout_oe_n) else $error("dout on bus");
	dout_rise_a: assert property (!o_dout_oe_n && $changed(o_dout) |-> i_sclk) else $error("dout moved");
	mask_off_a: assert property (mask_off |-> ##2 o_irq_oe_n) else $error("irq held");
	pulse_w_a: assert property ($rose(o_reactive_pulse_out) |->
		o_reactive_pulse_out [*8] ##1 !o_reactive_pulse_out) else $error("pulse width");
	cover property ($fell(o_irq_oe_n));
	cover property ($rose(o_reactive_pulse_out));
	cover property ($fell(o_dout_oe_n));
endmodule // mhs_checker
bind mhs_top mhs_checker u_chk (.*);

//--- mhs_defs.vh
// constants for the meter host serial pin block
`ifndef MHS_DEFS_VH
`define MHS_DEFS_VH
`define MHS_ADDR_W        8'd6
`define MHS_REG_MODE      6'h00
`define MHS_REG_NUM       6'h01
`define MHS_REG_DEN       6'h02
`define MHS_REG_STATUS    6'h03
`define MHS_REG_MASK      6'h04
`define MHS_REG_ENERGY_A  6'h05
`define MHS_REG_ENERGY_S  6'h06
`define MHS_REG_WAVE      6'h07
`define MHS_APB_MODE      12'h000
`define MHS_APB_NUM       12'h004
`define MHS_APB_DEN       12'h008
`define MHS_APB_STATUS    12'h00c
`define MHS_APB_MASK      12'h010
`define MHS_MODE_SRC_BIT  0
`define MHS_ST_AEHF_BIT   0
`define MHS_ST_VAEHF_BIT  1
`define MHS_ST_WAVE_BIT   2
`define MHS_NUM_RST       16'h0000
`define MHS_DEN_RST       16'h003f
`define MHS_MODE_RST      8'h00
`define MHS_MASK_RST      8'h00
`define MHS_CLK_HZ        20000000
`define MHS_WAVE_SPS      26000
`define MHS_WAVE_CYC      (`MHS_CLK_HZ / `MHS_WAVE_SPS)
`define MHS_PULSE_W       16'd8
`endif

//--- mhs_host.sv
// host serial master model for the four-wire port
`timescale 1ns/1ns
module mhs_host (
	input  wire i_mclk,
	output reg  o_cs_n = 1'b1,
	output reg  o_sclk = 1'b0,
	output reg  o_din  = 1'b0,
	input  wire i_dout,
	input  wire i_dout_oe_n
);
	// one 24 bit frame, clock idle low, bit set on rise and held over fall
	task xfer(input [23:0] tx, output [15:0] rx);
		integer i;
		begin
			rx = 16'h0000;
			@(posedge i_mclk) o_cs_n <= 1'b0;
			for (i = 23; i >= 0; i = i - 1) begin
				repeat (4) @(posedge i_mclk);
				o_sclk <= 1'b1;
				o_din <= tx[i];
				repeat (4) @(posedge i_mclk);
				o_sclk <= 1'b0;
				if (i < 16)
					rx = {rx[14:0], i_dout_oe_n ? ~rx[0] : i_dout};
			end
			repeat (4) @(posedge i_mclk);
			o_cs_n <= 1'b1;
			o_din <= ~o_din;
		end
	endtask
endmodule // mhs_host

//--- mhs_pulse_gen.v
// scaled frequency pulse generator for the secondary calibration output
`timescale 1ns/1ns
`include "mhs_defs.vh"
module mhs_pulse_gen #(
	parameter W = 16
) (
	input  wire         i_mclk,
	input  wire         i_resetn,
	input  wire         i_tick,
	input  wire [W-1:0] i_num,
	input  wire [W-1:0] i_den,
	output reg          o_pulse
);
	reg [W:0]   acc;
	reg [W-1:0] width_cnt;
	wire [W:0]  sum = acc + {1'b0, i_num} + 1'b1;

	// accumulate numerator+1, fire when past denominator, then subtract denominator+1
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc       <= {(W+1){1'b0}};
			width_cnt <= {W{1'b0}};
			o_pulse   <= 1'b0;
		end else begin
			if (i_tick && (sum > {1'b0, i_den})) begin
				acc       <= sum - {1'b0, i_den} - 1'b1;
				width_cnt <= `MHS_PULSE_W;
			end else begin
				if (i_tick) begin
					acc <= sum;
				end
				// width keeps counting while ticks that do not fire arrive
				if (width_cnt != {W{1'b0}}) begin
					width_cnt <= width_cnt - 1'b1;
				end
			end
			o_pulse <= (width_cnt != {W{1'b0}});
		end
	end
endmodule // mhs_pulse_gen

//--- mhs_serial_slave.v
// four-wire serial slave, pins sampled on the master clock
`timescale 1ns/1ns
`include "mhs_defs.vh"
module mhs_serial_slave (
	input  wire        i_mclk,
	input  wire        i_resetn,
	input  wire        i_cs_n,
	input  wire        i_sclk,
	input  wire        i_din,
	input  wire [15:0] i_rdata,
	output reg         o_dout,
	output reg         o_dout_oe_n,
	output reg  [5:0]  o_addr,
	output reg         o_wr,
	output reg  [15:0] o_wdata,
	output reg         o_rd
);
	reg        sclk_q;
	reg [4:0]  bit_cnt;
	reg [7:0]  cmd;
	reg [15:0] shift;
	reg        reading;
	wire       fall = sclk_q & ~i_sclk;
	wire       rise = ~sclk_q & i_sclk;

	// frame: 8 command bits (msb=write, low 6 = address), then 16 data bits
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			sclk_q      <= 1'b0;
			bit_cnt     <= 5'h00;
			cmd         <= 8'h00;
			shift       <= 16'h0000;
			reading     <= 1'b0;
			o_dout      <= 1'b0;
			o_dout_oe_n <= 1'b1;
			o_addr      <= 6'h00;
			o_wr        <= 1'b0;
			o_wdata     <= 16'h0000;
			o_rd        <= 1'b0;
		end else begin
			sclk_q <= i_sclk;
			o_wr   <= 1'b0;
			o_rd   <= 1'b0;
			if (i_cs_n) begin
				bit_cnt     <= 5'h00;
				reading     <= 1'b0;
				o_dout_oe_n <= 1'b1;
			end else if (fall) begin
				bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt < 5'd8) begin
					cmd <= {cmd[6:0], i_din};
					if (bit_cnt == 5'd7) begin
						o_addr  <= {cmd[4:0], i_din};
						reading <= ~cmd[6];
						o_rd    <= ~cmd[6];
					end
				end else if (bit_cnt < 5'd24) begin
					shift <= {shift[14:0], i_din};
					if (bit_cnt == 5'd23) begin
						o_wr    <= ~reading;
						o_wdata <= {shift[14:0], i_din};
					end
				end
				if (reading && bit_cnt == 5'd8) begin
					shift <= {i_rdata[14:0], 1'b0};
				end
			end else if (rise && reading && bit_cnt >= 5'd8 && bit_cnt < 5'd24) begin
				o_dout_oe_n <= 1'b0;
				o_dout      <= (bit_cnt == 5'd8) ? i_rdata[15] : shift[15];
			end else if (rise && bit_cnt >= 5'd24) begin
				o_dout_oe_n <= 1'b1;
			end
		end
	end
endmodule // mhs_serial_slave

//--- mhs_top.v
// meter host pins: serial slave, interrupt line, secondary pulse output
`timescale 1ns/1ns
`include "mhs_defs.vh"
module mhs_top (
	input  wire        i_mclk,
	input  wire        i_resetn,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	input  wire        i_cs_n,
	input  wire        i_sclk,
	input  wire        i_din,
	output wire        o_dout,
	output wire        o_dout_oe_n,
	input  wire        i_reactive_tick,
	input  wire        i_apparent_tick,
	input  wire        i_active_half,
	input  wire        i_apparent_half,
	output reg         o_irq_out,
	output reg         o_irq_oe_n,
	output reg         o_reactive_pulse_out
);
	reg  [7:0]  waveform_mode_reg;
	reg  [15:0] pulse_scale_numerator;
	reg  [15:0] pulse_scale_denominator;
	reg  [7:0]  status;
	reg  [7:0]  mask;
	reg  [15:0] wave_cnt;
	reg  [15:0] wave_sample;
	reg  [15:0] ser_rdata;
	wire [5:0]  ser_addr;
	wire        ser_wr;
	wire [15:0] ser_wdata;
	wire        pulse;
	wire        wave_evt = (wave_cnt == (`MHS_WAVE_CYC - 1));
	wire        apb_wr = i_psel & i_penable & i_pwrite;
	wire        apb_rd = i_psel & ~i_penable & ~i_pwrite;
	wire        src_apparent = waveform_mode_reg[`MHS_MODE_SRC_BIT];
	wire        sel_tick = src_apparent ? i_apparent_tick : i_reactive_tick;
	wire [7:0]  evt;
	wire [7:0]  clr;

	// decode of a mapped apb byte address
	function apb_hit;
		input [11:0] a;
		begin
			apb_hit = (a == `MHS_APB_MODE) || (a == `MHS_APB_NUM) || (a == `MHS_APB_DEN) ||
				(a == `MHS_APB_STATUS) || (a == `MHS_APB_MASK);
		end
	endfunction

	// hardware events feeding the sticky status
	assign evt = {5'h00, wave_evt, i_apparent_half, i_active_half};
	assign clr = (apb_wr && i_paddr == `MHS_APB_STATUS) ? i_pwdata[7:0] :
		(ser_wr && ser_addr == `MHS_REG_STATUS) ? ser_wdata[7:0] : 8'h00;

	// waveform sample rate divider, 26 ksps
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			wave_cnt    <= 16'h0000;
			wave_sample <= 16'h0000;
		end else if (wave_evt) begin
			wave_cnt    <= 16'h0000;
			wave_sample <= wave_sample + 16'h0001;
		end else begin
			wave_cnt <= wave_cnt + 16'h0001;
		end
	end

	// registers written from apb or serial port; set wins over clear
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			waveform_mode_reg       <= `MHS_MODE_RST;
			pulse_scale_numerator   <= `MHS_NUM_RST;
			pulse_scale_denominator <= `MHS_DEN_RST;
			mask                    <= `MHS_MASK_RST;
			status                  <= 8'h00;
		end else begin
			status <= (status & ~clr) | evt;
			if (apb_wr) begin
				case (i_paddr)
				`MHS_APB_MODE: waveform_mode_reg <= i_pwdata[7:0];
				`MHS_APB_NUM:  pulse_scale_numerator <= i_pwdata[15:0];
				`MHS_APB_DEN:  pulse_scale_denominator <= i_pwdata[15:0];
				`MHS_APB_MASK: mask <= i_pwdata[7:0];
				default: ;
				endcase
			end else if (ser_wr) begin
				case (ser_addr)
				`MHS_REG_MODE: waveform_mode_reg <= ser_wdata[7:0];
				`MHS_REG_NUM:  pulse_scale_numerator <= ser_wdata;
				`MHS_REG_DEN:  pulse_scale_denominator <= ser_wdata;
				`MHS_REG_MASK: mask <= ser_wdata[7:0];
				default: ;
				endcase
			end
		end
	end

	// serial read data mux
	always @* begin
		case (ser_addr)
		`MHS_REG_MODE:     ser_rdata = {8'h00, waveform_mode_reg};
		`MHS_REG_NUM:      ser_rdata = pulse_scale_numerator;
		`MHS_REG_DEN:      ser_rdata = pulse_scale_denominator;
		`MHS_REG_STATUS:   ser_rdata = {8'h00, status};
		`MHS_REG_MASK:     ser_rdata = {8'h00, mask};
		`MHS_REG_WAVE:     ser_rdata = wave_sample;
		default:           ser_rdata = 16'h0000;
		endcase
	end

	// apb slave: one wait-free access phase, read data set in setup
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_prdata  <= 32'h0000_0000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~apb_hit(i_paddr);
			if (apb_rd) begin
				case (i_paddr)
				`MHS_APB_MODE:   o_prdata <= {24'h000000, waveform_mode_reg};
				`MHS_APB_NUM:    o_prdata <= {16'h0000, pulse_scale_numerator};
				`MHS_APB_DEN:    o_prdata <= {16'h0000, pulse_scale_denominator};
				`MHS_APB_STATUS: o_prdata <= {24'h000000, status};
				`MHS_APB_MASK:   o_prdata <= {24'h000000, mask};
				default:         o_prdata <= 32'h0000_0000;
				endcase
			end else if (i_psel & ~i_penable) begin
				o_prdata <= 32'h0000_0000; // writes read back zero
			end
		end
	end

	// open-drain interrupt: pull low only while an unmasked bit is set
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_irq_out  <= 1'b0;
			o_irq_oe_n <= 1'b1;
		end else begin
			o_irq_out  <= 1'b0;
			o_irq_oe_n <= ~|(status & mask);
		end
	end

	// registered pulse output
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_reactive_pulse_out <= 1'b0;
		end else begin
			o_reactive_pulse_out <= pulse;
		end
	end

	mhs_pulse_gen #(
		.W(16)
	) u_pulse (
		.i_mclk  (i_mclk),
		.i_resetn(i_resetn),
		.i_tick  (sel_tick),
		.i_num   (pulse_scale_numerator),
		.i_den   (pulse_scale_denominator),
		.o_pulse (pulse)
	);

	mhs_serial_slave u_ser (
		.i_mclk     (i_mclk),
		.i_resetn   (i_resetn),
		.i_cs_n     (i_cs_n),
		.i_sclk     (i_sclk),
		.i_din      (i_din),
		.i_rdata    (ser_rdata),
		.o_dout     (o_dout),
		.o_dout_oe_n(o_dout_oe_n),
		.o_addr     (ser_addr),
		.o_wr       (ser_wr),
		.o_wdata    (ser_wdata),
		.o_rd       ()
	);
endmodule // mhs_top

//--- mhs_top_bench.sv
// self-checking bench for the meter host pin block
`timescale 1ns/1ns
module mhs_top_bench;
	reg         i_mclk   = 1'b0;
	reg         i_resetn = 1'b0;
	reg         psel     = 1'b0;
	reg         pen      = 1'b0;
	reg         pwr      = 1'b0;
	reg  [11:0] paddr    = 12'h000;
	reg  [31:0] pwdata   = 32'h0;
	reg  [3:0]  ev       = 4'h0;
	reg         pq       = 1'b0;
	reg         e;
	reg  [31:0] r;
	reg  [15:0] rx;
	wire [31:0] prdata;
	wire        pready, pslverr, cs_n, sclk, din, dout, dout_oe_n, irq_out, irq_oe_n, pulse;
	integer     mismatches = 0, checks_done = 0, cyc = 0, pc = 0, i;
	mhs_top DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_dout(dout),
		.o_dout_oe_n(dout_oe_n), .i_reactive_tick(ev[0]), .i_apparent_tick(ev[1]),
		.i_active_half(ev[2]), .i_apparent_half(ev[3]), .o_irq_out(irq_out),
		.o_irq_oe_n(irq_oe_n), .o_reactive_pulse_out(pulse));
	mhs_host host (.i_mclk(i_mclk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din),
		.i_dout(dout), .i_dout_oe_n(dout_oe_n));
	// clock, 50 ns period
	initial forever #25 i_mclk = ~i_mclk;
	// pulse counter and hang limit
	always @(posedge i_mclk) begin
		if (pulse && !pq) pc = pc + 1;
		pq = pulse;
		cyc = cyc + 1;
		if (cyc == 40000) begin
			mismatches = mismatches + 1;
			final_report;
		end
	end
	task chk(input [31:0] s, input [31:0] x);
		begin
			checks_done = checks_done + 1;
			if (s !== x) begin
				mismatches = mismatches + 1;
				$display("[ERR] %0t %h %h", $time, s, x);
			end
		end
	endtask
	task final_report;
		begin
			if (mismatches == 0 && checks_done > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge i_mclk);
			psel <= 1'b1;
			pwr <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge i_mclk) pen <= 1'b1;
			do @(posedge i_mclk); while (pready !== 1'b1);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask
	task pulse_in(input [3:0] m, input integer n);
		repeat (n) begin
			@(posedge i_mclk) ev <= m;
			@(posedge i_mclk) ev <= 4'h0;
			repeat (20) @(posedge i_mclk);
		end
	endtask
	task t_regs;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				apb(1'b0, 12'(i * 4), 32'h0);
				chk(r & ((i == 3) ? 32'h3 : 32'hffffffff), (i == 2) ? 32'h3f : 32'h0);
			end
			apb(1'b1, 12'h014, 32'h5);
			chk(e, 1);
			apb(1'b0, 12'h014, 32'h0);
			chk(e, 1);
			chk(r, 32'h0);
		end
	endtask
	task t_serial;
		begin
			host.xfer(24'h811234, rx);
			apb(1'b0, 12'h004, 32'h0);
			chk(r, 32'h1234);
			apb(1'b1, 12'h008, 32'h00a5);
			host.xfer(24'h020000, rx);
			chk(rx, 16'h00a5);
			repeat (2) @(posedge i_mclk);
			chk(dout_oe_n, 1);
		end
	endtask
	task t_irq;
		begin
			apb(1'b1, 12'h010, 32'h3);
			pulse_in(4'h4, 1);
			chk({irq_out, irq_oe_n}, 0);
			apb(1'b0, 12'h00c, 32'h0);
			chk(r & 3, 1);
			apb(1'b1, 12'h00c, 32'h3);
			repeat (4) @(posedge i_mclk);
			chk(irq_oe_n, 1);
			pulse_in(4'h8, 1);
			chk(irq_oe_n, 0);
			apb(1'b1, 12'h010, 32'h0);
			repeat (4) @(posedge i_mclk);
			chk(irq_oe_n, 1);
			pulse_in(4'h4, 1);
			chk(irq_oe_n, 1);
			apb(1'b1, 12'h00c, 32'h7);
			apb(1'b1, 12'h010, 32'h4);
			for (i = 0; i < 800 && irq_oe_n !== 1'b0; i = i + 1) @(posedge i_mclk);
			chk(irq_oe_n, 0);
			apb(1'b1, 12'h010, 32'h0);
		end
	endtask
	task t_pulse(input [3:0] m, input [31:0] mode, input x);
		begin
			apb(1'b1, 12'h000, mode);
			pc = 0;
			pulse_in(m, 4);
			chk(pc != 0, x);
		end
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge i_mclk);
		i_resetn <= 1'b1;
		t_regs;
		t_serial;
		t_irq;
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h008, 32'h0);
		t_pulse(4'h1, 32'h0, 1);
		t_pulse(4'h2, 32'h0, 0);
		t_pulse(4'h1, 32'h1, 0);
		t_pulse(4'h2, 32'h1, 1);
		apb(1'b1, 12'h008, 32'hffff);
		t_pulse(4'h2, 32'h1, 0);
		final_report;
	end
endmodule // mhs_top_bench
